// File: hdl/ee_i2c_slave.sv
// Two-wire bus slave with a 1024 x 8 self-timed programmable array.
// Assumes open-drain SDA resolved outside; SCL, SDA and both pins are asynchronous.
// Operation
// - SDA falling with SCL high is start; SDA rising with SCL high is stop.
// - SDA changes only while SCL low; it is sampled on SCL high.
// - Selected device drives ack low from eighth falling edge through ninth clock.
// - During read data the ninth clock slot is released for the master.
// - Programming starts only on a stop after the twenty-seventh clock.
// - Selected only when select bit equals the level on the select input.
// - Upper two address bits come from write-select byte, lower from next byte.
// - Matching write-select during programming aborts that programming.
// - Read-select is ignored and not acked while programming is active.
// - Random read: write-select, address, repeated start, read-select, then data.
// - Addressed word loads during ack clock nine; first bit after its fall.
// - Each further shift clock presents the next data bit.
// - Master ack after a read byte increments the address counter.
// - Address counter wraps from the last location back to zero.
// - Stop during read releases SDA and returns the sequencer to idle.
// - Programming erases the word to ones then writes its zero bits.
// - Erase plus write completes within 20 ms, typically 10 ms.
// - Write phase skipped for all-ones data; erase skipped for erased word.
// - SDA released at reset; stop launching programming keeps the engine.
// - Write-select, address 0, data FF with erase pin high erases everything.
// - Select byte is 1010, two bits, select bit, then write 0 or read 1.
`timescale 1ns/1ps
`default_nettype none
`include "ee_defines.svh"

// Queue of launched programming requests; drains into the engine.
module ee_sync_fifo #(
	parameter int WIDTH = `EE_FIFO_W,
	parameter int DEPTH = `EE_FIFO_D,
	parameter int AW = 4
) (
	input wire logic mclk, // System clock.
	input wire logic rst_b, // Asynchronous reset, active low.
	input wire logic flush, // Empties the queue.
	input wire logic in_valid, // Write request.
	output logic in_ready, // Room for one more word.
	input wire logic [WIDTH-1:0] in_data, // Word written.
	output logic out_valid, // A word is available.
	input wire logic out_ready, // Consumer takes the word.
	output logic [WIDTH-1:0] out_data // Oldest word.
);
	logic [WIDTH-1:0] store_q [0:DEPTH-1];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// Full and empty come straight from the occupancy count.
	assign in_ready = (cnt_q < (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data = store_q[rd_q];

	// Storage array holds no reset.
	always_ff @(posedge mclk) begin
		if (push) begin
			store_q[wr_q] <= in_data;
		end
	end

	// Pointers and count; flush wins over push and pop.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else if (flush) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			wr_q <= wr_q + AW'(push);
			rd_q <= rd_q + AW'(pop);
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : ee_sync_fifo

// Slave sequencer, programming engine and array.
module ee_i2c_slave #(
	parameter int ERASE_CYCLES = `EE_ERASE_CYC,
	parameter int WRITE_CYCLES = `EE_WRITE_CYC,
	parameter int BULK_CYCLES = `EE_BULK_CYC
) (
	input wire logic mclk, // System clock, 10 MHz.
	input wire logic rst_b, // Asynchronous reset, active low.
	input wire logic scl_i, // Bus clock from the master.
	input wire logic sda_i, // Resolved level of the data line.
	output logic sda_o, // Data line output value, always low.
	output logic sda_oe, // High while the data line is pulled low.
	input wire logic chip_select, // Select input strap level.
	input wire logic bulk_erase_pin, // High requests whole-array erase.
	output logic prog_busy // High while programming is pending or active.
);
	ee_pkg::ee_bus_state_type state_q;
	ee_pkg::ee_prog_state_type eng_q;
	logic [7:0] mem_q [0:1023];
	wire [3:0] pin_s;
	logic scl_q, sda_q, scl_s, sda_s, cs_s, bulk_s;
	logic [3:0] bitcnt_q;
	logic [1:0] idx_q;
	logic [7:0] shift_q, data_q, prog_data_q;
	logic [9:0] addr_q, prog_addr_q;
	logic [10:0] sweep_q;
	logic [`EE_TMR_W-1:0] timer_q;
	logic wmode_q, rd_q, armed_q, macked_q, oe_q;
	logic fifo_in_ready, fifo_out_valid;
	logic [`EE_FIFO_W-1:0] fifo_out;

	// True when a select byte carries the fixed code and our select level.
	function automatic logic sel_match(input logic [7:0] b, input logic cs);
		sel_match = (b[7:4] == `EE_SEL_CODE) && (b[`EE_SEL_CS_BIT] == cs);
	endfunction : sel_match

	// Two-stage synchronisers for SCL, SDA, select and erase pins.
	wire [3:0] pin_raw = {bulk_erase_pin, chip_select, sda_i, scl_i};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			logic [1:0] s_q;
			always_ff @(posedge mclk or negedge rst_b) begin
				if (!rst_b) s_q <= 2'h3;
				else s_q <= {s_q[0], pin_raw[gi]};
			end
			assign pin_s[gi] = s_q[1];
		end
	endgenerate
	assign scl_s = pin_s[0];
	assign sda_s = pin_s[1];
	assign cs_s = pin_s[2];
	assign bulk_s = pin_s[3];

	// Previous synchronised samples for edge detection.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	// Bus events taken from synchronised samples only.
	wire scl_rise = scl_s && !scl_q;
	wire scl_fall = !scl_s && scl_q;
	wire start_det = scl_s && scl_q && sda_q && !sda_s;
	wire stop_det = scl_s && scl_q && !sda_q && sda_s;
	wire byte_done = (state_q == ee_pkg::BUS_RX) && scl_fall && (bitcnt_q == `EE_BYTE_BITS);
	wire is_read = shift_q[`EE_SEL_RW_BIT];
	wire sel_ok = sel_match(shift_q, cs_s);
	wire abort_w = byte_done && (idx_q == `EE_IDX_SELECT) && sel_ok && !is_read;
	wire busy_w = (eng_q != ee_pkg::PRG_IDLE) || fifo_out_valid;
	wire [7:0] mem_rd = mem_q[addr_q];

	// Decide whether the byte just received is acknowledged.
	wire take_sel = sel_ok && (!is_read || !busy_w);
	wire take_byte = (idx_q == `EE_IDX_SELECT) ? take_sel :
		(idx_q == `EE_IDX_ADDR) ? wmode_q :
		(idx_q == `EE_IDX_DATA) ? (wmode_q && fifo_in_ready) : 1'b0;

	// Launch request: stop after the full three-byte write.
	wire push = stop_det && armed_q && wmode_q;
	wire bulk_req = bulk_s && (addr_q == `EE_ADDR_ZERO) && (data_q == `EE_ERASED);

	// Bus sequencer.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ee_pkg::BUS_IDLE;
			oe_q <= 1'b0;
			bitcnt_q <= '0;
			idx_q <= '0;
			shift_q <= '0;
			data_q <= '0;
			addr_q <= '0;
			wmode_q <= 1'b0;
			rd_q <= 1'b0;
			armed_q <= 1'b0;
			macked_q <= 1'b0;
		end else if (stop_det) begin
			state_q <= ee_pkg::BUS_IDLE;
			oe_q <= 1'b0;
			armed_q <= 1'b0;
			wmode_q <= 1'b0;
			rd_q <= 1'b0;
		end else if (start_det) begin
			state_q <= ee_pkg::BUS_RX;
			oe_q <= 1'b0;
			bitcnt_q <= '0;
			idx_q <= `EE_IDX_SELECT;
			armed_q <= 1'b0;
			rd_q <= 1'b0;
		end else begin
			case (state_q)
				ee_pkg::BUS_RX: begin
					if (scl_rise) begin
						shift_q <= {shift_q[6:0], sda_s};
						bitcnt_q <= bitcnt_q + 4'h1;
					end else if (byte_done) begin
						state_q <= take_byte ? ee_pkg::BUS_ACK : ee_pkg::BUS_IGNORE;
						oe_q <= take_byte;
						if (idx_q != `EE_IDX_EXTRA) idx_q <= idx_q + 2'h1;
						if (idx_q == `EE_IDX_EXTRA) armed_q <= 1'b0;
						if (idx_q == `EE_IDX_SELECT && take_sel) begin
							wmode_q <= !is_read;
							rd_q <= is_read;
							if (!is_read) addr_q[9:8] <= shift_q[3:2];
						end
						if (idx_q == `EE_IDX_ADDR && wmode_q) addr_q[7:0] <= shift_q;
						if (idx_q == `EE_IDX_DATA && take_byte) data_q <= shift_q;
					end
				end
				ee_pkg::BUS_ACK: begin
					if (scl_rise && rd_q) data_q <= mem_rd;
					if (scl_fall) begin
						bitcnt_q <= '0;
						state_q <= rd_q ? ee_pkg::BUS_TX : ee_pkg::BUS_RX;
						oe_q <= rd_q && !data_q[7];
						armed_q <= !rd_q && (idx_q == `EE_IDX_EXTRA);
					end
				end
				ee_pkg::BUS_TX: begin
					if (scl_fall) begin
						if (bitcnt_q == `EE_LAST_TX_BIT) begin
							state_q <= ee_pkg::BUS_MACK;
							oe_q <= 1'b0;
						end else begin
							data_q <= {data_q[6:0], 1'b1};
							oe_q <= !data_q[6];
							bitcnt_q <= bitcnt_q + 4'h1;
						end
					end
				end
				ee_pkg::BUS_MACK: begin
					if (scl_rise) begin
						macked_q <= !sda_s;
						if (!sda_s) addr_q <= addr_q + 10'h001;
					end else if (scl_fall) begin
						bitcnt_q <= '0;
						state_q <= macked_q ? ee_pkg::BUS_TX : ee_pkg::BUS_IGNORE;
						if (macked_q) data_q <= mem_rd;
						oe_q <= macked_q && !mem_rd[7];
					end
				end
				ee_pkg::BUS_IDLE, ee_pkg::BUS_IGNORE: begin
					oe_q <= 1'b0;
				end
				default: begin
					state_q <= ee_pkg::BUS_IDLE;
					oe_q <= 1'b0;
				end
			endcase
		end
	end

	assign sda_o = 1'b0;
	assign sda_oe = oe_q;
	assign prog_busy = busy_w;

	// Launched requests wait here; the engine takes one when idle.
	wire eng_idle = (eng_q == ee_pkg::PRG_IDLE);
	wire pop = fifo_out_valid && eng_idle && !abort_w;
	ee_sync_fifo #(.WIDTH(`EE_FIFO_W), .DEPTH(`EE_FIFO_D), .AW(4)) u_queue (
		.mclk(mclk),
		.rst_b(rst_b),
		.flush(abort_w),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data({bulk_req, addr_q, data_q}),
		.out_valid(fifo_out_valid),
		.out_ready(pop),
		.out_data(fifo_out)
	);

	// Engine decisions on the word at the head of the queue.
	wire q_bulk = fifo_out[18];
	wire [9:0] q_addr = fifo_out[17:8];
	wire [7:0] q_data = fifo_out[7:0];
	wire need_erase = (mem_q[q_addr] != `EE_ERASED);
	wire need_write = (q_data != `EE_ERASED);
	wire tmr_done = (timer_q == '0);

	// Array write port driven by the engine.
	wire sweep_on = (eng_q == ee_pkg::PRG_BULK) && !sweep_q[10];
	wire erase_we = (eng_q == ee_pkg::PRG_ERASE) && tmr_done;
	wire write_we = (eng_q == ee_pkg::PRG_WRITE) && tmr_done;
	wire mem_we = sweep_on || erase_we || write_we;
	wire [9:0] mem_wa = sweep_on ? sweep_q[9:0] : prog_addr_q;
	wire [7:0] mem_wd = write_we ? (mem_q[prog_addr_q] & prog_data_q) : `EE_ERASED;

	always_ff @(posedge mclk) begin
		if (mem_we) mem_q[mem_wa] <= mem_wd;
	end

	// Self-timed programming engine; a matching write-select aborts it.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			eng_q <= ee_pkg::PRG_IDLE;
			timer_q <= '0;
			sweep_q <= '0;
			prog_addr_q <= '0;
			prog_data_q <= '0;
		end else if (abort_w) begin
			eng_q <= ee_pkg::PRG_IDLE;
		end else begin
			case (eng_q)
				ee_pkg::PRG_IDLE: begin
					if (pop) begin
						prog_addr_q <= q_addr;
						prog_data_q <= q_data;
						sweep_q <= '0;
						if (q_bulk) begin
							eng_q <= ee_pkg::PRG_BULK;
							timer_q <= `EE_TMR_W'(BULK_CYCLES - 1);
						end else if (need_erase) begin
							eng_q <= ee_pkg::PRG_ERASE;
							timer_q <= `EE_TMR_W'(ERASE_CYCLES - 1);
						end else if (need_write) begin
							eng_q <= ee_pkg::PRG_WRITE;
							timer_q <= `EE_TMR_W'(WRITE_CYCLES - 1);
						end
					end
				end
				ee_pkg::PRG_ERASE: begin
					timer_q <= timer_q - `EE_TMR_W'(1);
					if (tmr_done) begin
						eng_q <= (prog_data_q != `EE_ERASED) ? ee_pkg::PRG_WRITE : ee_pkg::PRG_IDLE;
						timer_q <= `EE_TMR_W'(WRITE_CYCLES - 1);
					end
				end
				ee_pkg::PRG_WRITE: begin
					timer_q <= timer_q - `EE_TMR_W'(1);
					if (tmr_done) eng_q <= ee_pkg::PRG_IDLE;
				end
				ee_pkg::PRG_BULK: begin
					if (sweep_on) sweep_q <= sweep_q + 11'h001;
					timer_q <= timer_q - `EE_TMR_W'(1);
					if (tmr_done) eng_q <= ee_pkg::PRG_IDLE;
				end
				default: eng_q <= ee_pkg::PRG_IDLE;
			endcase
		end
	end

	// Helper: cycles spent in one erase or write job; held at zero during bulk erase.
	logic [`EE_TMR_W:0] job_cnt_q;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) job_cnt_q <= '0;
		else if (eng_idle || eng_q == ee_pkg::PRG_BULK) job_cnt_q <= '0;
		else job_cnt_q <= job_cnt_q + (`EE_TMR_W+1)'(1);
	end

	start_seen_a: assert property (@(posedge mclk) disable iff (!rst_b)
		start_det && !stop_det |=> state_q == ee_pkg::BUS_RX && idx_q == `EE_IDX_SELECT && !sda_oe)
		else $error("Start did not open a new select byte.");
	ack_drive_a: assert property (@(posedge mclk) disable iff (!rst_b)
		byte_done && take_byte && !stop_det && !start_det |=> sda_oe && state_q == ee_pkg::BUS_ACK)
		else $error("Accepted byte was not acknowledged.");
	mack_release_a: assert property (@(posedge mclk) disable iff (!rst_b)
		state_q == ee_pkg::BUS_MACK |-> !sda_oe)
		else $error("Data line driven during master acknowledge slot.");
	launch_stop_a: assert property (@(posedge mclk) disable iff (!rst_b)
		push |-> $past(state_q) != ee_pkg::BUS_TX && wmode_q && idx_q == `EE_IDX_EXTRA)
		else $error("Programming launched without a full write sequence.");
	select_match_a: assert property (@(posedge mclk) disable iff (!rst_b)
		byte_done && idx_q == `EE_IDX_SELECT && shift_q[`EE_SEL_CS_BIT] != cs_s |=> !sda_oe)
		else $error("Acked a select byte for the other device.");
	abort_prog_a: assert property (@(posedge mclk) disable iff (!rst_b)
		abort_w |=> eng_idle && !fifo_out_valid)
		else $error("Write-select did not abort programming.");
	poll_ignore_a: assert property (@(posedge mclk) disable iff (!rst_b)
		byte_done && idx_q == `EE_IDX_SELECT && is_read && busy_w && !stop_det && !start_det
		|=> state_q == ee_pkg::BUS_IGNORE ##1 !sda_oe)
		else $error("Read-select acked while programming.");
	addr_wrap_a: assert property (@(posedge mclk) disable iff (!rst_b)
		state_q == ee_pkg::BUS_MACK && scl_rise && !sda_s && addr_q == `EE_ADDR_LAST && !stop_det && !start_det
		|=> addr_q == `EE_ADDR_ZERO)
		else $error("Address counter did not wrap to zero.");
	stop_idle_a: assert property (@(posedge mclk) disable iff (!rst_b)
		stop_det |=> state_q == ee_pkg::BUS_IDLE && !sda_oe)
		else $error("Stop did not return the sequencer to idle.");
	prog_time_a: assert property (@(posedge mclk) disable iff (!rst_b)
		job_cnt_q <= (`EE_TMR_W+1)'(ERASE_CYCLES + WRITE_CYCLES))
		else $error("Programming exceeded its time budget.");
endmodule : ee_i2c_slave

`default_nettype wire

// File: hdl/ee_defines.svh
// Constants for the two-wire 1024 x 8 nonvolatile memory slave.
// Assumes a 10 MHz system clock; all times are converted to cycles here.
`ifndef EE_DEFINES_SVH
`define EE_DEFINES_SVH

// System clock rate in MHz, used to turn microseconds into cycles.
`define EE_CLK_MHZ 10
// Erase phase and write phase each take half of the typical 10 ms.
`define EE_ERASE_US 5000
`define EE_WRITE_US 5000
// Whole-array erase time, 20 ms.
`define EE_BULK_US 20000
`define EE_ERASE_CYC (`EE_ERASE_US * `EE_CLK_MHZ)
`define EE_WRITE_CYC (`EE_WRITE_US * `EE_CLK_MHZ)
`define EE_BULK_CYC (`EE_BULK_US * `EE_CLK_MHZ)

// Select byte layout: fixed code in the upper nibble.
`define EE_SEL_CODE 4'hA
`define EE_SEL_CS_BIT 1
`define EE_SEL_RW_BIT 0
// Bit counter value once a whole byte has been shifted in.
`define EE_BYTE_BITS 4'h8
`define EE_LAST_TX_BIT 4'h7
// Byte positions within a transfer.
`define EE_IDX_SELECT 2'h0
`define EE_IDX_ADDR 2'h1
`define EE_IDX_DATA 2'h2
`define EE_IDX_EXTRA 2'h3
// Erased word value and the address used for whole-array erase.
`define EE_ERASED 8'hFF
`define EE_ADDR_ZERO 10'h000
`define EE_ADDR_LAST 10'h3FF
// Timer width and write queue shape.
`define EE_TMR_W 18
`define EE_FIFO_W 19
`define EE_FIFO_D 16

`endif

// File: hdl/ee_pkg.sv
// Types shared by the two-wire memory slave.
// Assumes ee_defines.svh supplies the numeric constants.
package ee_pkg;

	// Serial bus sequencer states.
	typedef enum logic [2:0] {BUS_IDLE, BUS_RX, BUS_ACK, BUS_TX, BUS_MACK, BUS_IGNORE} ee_bus_state_type;

	// Self-timed programming engine states.
	typedef enum logic [1:0] {PRG_IDLE, PRG_ERASE, PRG_WRITE, PRG_BULK} ee_prog_state_type;

endpackage : ee_pkg

// File: hdl/ee_fifo_note.sv
// Holds no logic; the write queue sits beside the slave sequencer.

// File: testbench/ee_bus_master.sv
// Two-wire bus master model that drives the memory slave from the far side.
// Assumes the bench resolves the open-drain data line and pulls it up.
`timescale 1ns/1ps
`default_nettype none

module ee_bus_master (
	input wire logic mclk, // System clock that paces every bus edge.
	input wire logic sda, // Resolved data line level.
	output logic scl, // Bus clock; stands high outside frames.
	output logic sda_pull // High while the master pulls data low.
);
	// Idle bus: clock high, data released to the pull-up.
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	// Waits n system clocks, then steps just past the edge.
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick

	// Start or repeated start; data falls while the clock is high.
	// A repeated start first releases data, then raises the clock.
	task automatic start_cond();
		if (!scl) begin
			sda_pull = 1'b0;
			tick(4);
			scl = 1'b1;
			tick(4);
		end
		sda_pull = 1'b1;
		tick(4);
		scl = 1'b0;
	endtask : start_cond

	// Stop; data rises while the clock is high, then the bus rests.
	task automatic stop_cond();
		tick(2);
		sda_pull = 1'b1;
		tick(2);
		scl = 1'b1;
		tick(4);
		sda_pull = 1'b0;
		tick(8);
	endtask : stop_cond

	// One clock: data changes mid-low, is sampled at the end of high.
	task automatic bit_cycle(input logic b, output logic s);
		tick(2);
		sda_pull = !b;
		tick(2);
		scl = 1'b1;
		tick(3);
		s = sda;
		tick(1);
		scl = 1'b0;
	endtask : bit_cycle

	// Byte sent MSB first, then the acknowledge clock; low ack means taken.
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(d[i], s);
		end
		bit_cycle(1'b1, ack);
	endtask : wr_byte

	// Eight clocks collect a byte, then the master's own acknowledge.
	task automatic rd_byte(input logic nack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(1'b1, s);
			d[i] = s;
		end
		bit_cycle(nack, s);
	endtask : rd_byte
endmodule : ee_bus_master

`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the two-wire memory slave.
// Assumes the design files are compiled first; programming times are shortened.
`timescale 1ns/1ps
`default_nettype none

module tb;
	localparam int ERASE_N = 200;
	localparam int WRITE_N = 200;
	localparam int BULK_N = 1100;
	logic mclk, rst_b, sda, scl, sda_pull, sda_o, sda_oe, chip_select, bulk_erase_pin, prog_busy;
	int mismatches, checks_done, cycles;

	// Open-drain data line with a pull-up.
	assign sda = !((sda_oe & !sda_o) | sda_pull);

	ee_i2c_slave #(.ERASE_CYCLES(ERASE_N), .WRITE_CYCLES(WRITE_N), .BULK_CYCLES(BULK_N)) i_dut (
		.mclk(mclk), .rst_b(rst_b), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
		.chip_select(chip_select), .bulk_erase_pin(bulk_erase_pin), .prog_busy(prog_busy));

	ee_bus_master i_mst (.mclk(mclk), .sda(sda), .scl(scl), .sda_pull(sda_pull));

	// 10 MHz system clock.
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// Cuts a hang short after far more cycles than the tests need.
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			$display("[FAIL] timeout expected end seen hang");
			finish_test();
		end
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : finish_test

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic rng(input string what, input int lo, input int hi, input int v);
		checks_done++;
		if (v < lo || v > hi) begin
			mismatches++;
			$display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, v);
		end
	endtask : rng

	// Select, address and data bytes of a write, each acknowledged.
	task automatic send3(input logic [9:0] a, input logic [7:0] d);
		logic ack;
		i_mst.start_cond();
		i_mst.wr_byte({4'hA, a[9:8], 1'b1, 1'b0}, ack);
		chk("write select ack", 1'b0, ack);
		i_mst.wr_byte(a[7:0], ack);
		chk("address ack", 1'b0, ack);
		i_mst.wr_byte(d, ack);
		chk("data ack", 1'b0, ack);
	endtask : send3

	// Write launched by stop; optional polling; returns cycles until idle.
	task automatic prog(input logic [9:0] a, input logic [7:0] d, input logic be, input logic poll, output int cyc);
		realtime t0;
		logic ack;
		logic [7:0] q;
		int n;
		send3(a, d);
		bulk_erase_pin = be;
		i_mst.stop_cond();
		t0 = $realtime;
		if (poll) begin
			chk("busy after stop", 1'b1, prog_busy);
			i_mst.start_cond();
			i_mst.wr_byte(8'hA3, ack);
			chk("poll while busy", 1'b1, ack);
			i_mst.stop_cond();
		end
		n = 0;
		while (prog_busy !== 1'b0 && n < 3000) begin
			@(posedge mclk);
			#1;
			n++;
		end
		cyc = int'(($realtime - t0) / 100.0);
		bulk_erase_pin = 1'b0;
		if (poll) begin
			i_mst.start_cond();
			i_mst.wr_byte(8'hA3, ack);
			chk("poll when done", 1'b0, ack);
			i_mst.rd_byte(1'b1, q);
			chk("poll read data", {8'h00, d}, {8'h00, q});
			i_mst.stop_cond();
		end
	endtask : prog

	// Random read followed by sequential bytes; last byte not acknowledged.
	task automatic rd_seq(input logic [9:0] a, input logic [7:0] exp [$]);
		logic ack;
		logic [7:0] q;
		i_mst.start_cond();
		i_mst.wr_byte({4'hA, a[9:8], 1'b1, 1'b0}, ack);
		i_mst.wr_byte(a[7:0], ack);
		i_mst.start_cond();
		i_mst.wr_byte(8'hA3, ack);
		chk("read select ack", 1'b0, ack);
		foreach (exp[i]) begin
			i_mst.rd_byte(i == exp.size() - 1, q);
			chk("read data", exp[i], q);
		end
		i_mst.stop_cond();
		chk("released after stop", 1'b0, sda_oe);
	endtask : rd_seq

	// Wrong select bit and wrong code refused; matching strap low works; early stop.
	task automatic s_select();
		logic ack;
		i_mst.start_cond();
		i_mst.wr_byte(8'hA0, ack);
		chk("wrong select bit", 1'b1, ack);
		i_mst.stop_cond();
		i_mst.start_cond();
		i_mst.wr_byte(8'hB2, ack);
		chk("wrong code", 1'b1, ack);
		i_mst.stop_cond();
		chip_select = 1'b0;
		i_mst.start_cond();
		i_mst.wr_byte(8'hA0, ack);
		chk("strap low select", 1'b0, ack);
		i_mst.wr_byte(8'h12, ack);
		i_mst.stop_cond();
		chk("no launch early stop", 1'b0, prog_busy);
		chip_select = 1'b1;
	endtask : s_select

	// A write-select during programming aborts it; the new write lands.
	task automatic s_abort();
		logic ack;
		send3(10'h010, 8'h00);
		i_mst.stop_cond();
		i_mst.start_cond();
		i_mst.wr_byte({4'hA, 2'b00, 1'b1, 1'b0}, ack);
		chk("abort select ack", 1'b0, ack);
		chk("busy after abort", 1'b0, prog_busy);
		i_mst.wr_byte(8'h11, ack);
		i_mst.wr_byte(8'h77, ack);
		i_mst.stop_cond();
		repeat (ERASE_N + WRITE_N + 20) @(posedge mclk);
		rd_seq(10'h010, '{8'hFF, 8'h77});
	endtask : s_abort

	initial begin
		int cyc;
		rst_b = 1'b0;
		chip_select = 1'b1;
		bulk_erase_pin = 1'b0;
		mismatches = 0;
		checks_done = 0;
		cycles = 0;
		repeat (8) @(posedge mclk);
		#1;
		chk("oe in reset", 1'b0, sda_oe);
		chk("busy in reset", 1'b0, prog_busy);
		chk("open drain value", 1'b0, sda_o);
		rst_b = 1'b1;
		i_mst.tick(4);
		s_select();
		prog(10'h000, 8'hFF, 1'b1, 1'b0, cyc);
		rng("bulk erase time", 1024, BULK_N + 10, cyc);
		rd_seq(10'h3FF, '{8'hFF, 8'hFF});
		prog(10'h3FF, 8'h5A, 1'b0, 1'b0, cyc);
		rng("erase skipped", WRITE_N - 10, WRITE_N + 10, cyc);
		prog(10'h3FF, 8'hA5, 1'b0, 1'b1, cyc);
		rng("erase and write", ERASE_N + WRITE_N - 10, ERASE_N + WRITE_N + 10, cyc);
		prog(10'h000, 8'hFF, 1'b0, 1'b0, cyc);
		rng("both skipped", 0, ERASE_N - 1, cyc);
		prog(10'h001, 8'h3C, 1'b0, 1'b0, cyc);
		rd_seq(10'h3FF, '{8'hA5, 8'hFF, 8'h3C});
		s_abort();
		finish_test();
	end
endmodule : tb

`default_nettype wire
